// ### pcch_cmd_handler.v
// Contract
// - comparator-off command disables comparator, plain ACK
// - pwm args: io, duty, format, 4-byte value
// - io index from zero, below channel count
// - duty valid from 1 to 99 percent
// - format codes 0..3 select unit and type
// - pwm accepted: configure, ACK with 4 bytes
// - iv set: 16 bytes lsb first, stored
// - key set: 16 bytes lsb first, replaces key
// - encrypted payloads padded to 16-byte blocks
// - same aes config as tag crypto commands
// - iv ACK empty, encrypted under new iv
// - key ACK empty, encrypted under new key
// - iv read: ACK plus sixteen iv bytes
`timescale 1ns/1ns
`include "pcch_consts.vh"
module pcch_cmd_handler #(
   parameter PWM_CHANNELS = 4,   // number of pwm-capable io
   parameter IO_W         = 8    // width of io index port
) (
   input  wire         clk,
   input  wire         reset,
   // command stream, one byte per beat from packet deframer
   input  wire         cmd_start,       // first byte is the command code
   input  wire         cmd_valid,
   input  wire [7:0]   cmd_byte,
   input  wire         cmd_last,        // final argument byte
   output wire         cmd_ready,
   // answer stream to packet framer
   output reg          rsp_start,       // begins answer, carries status
   output reg  [7:0]   rsp_status,
   output reg          rsp_valid,       // data byte beat
   output reg  [7:0]   rsp_byte,
   output reg          rsp_last,        // final beat of answer
   output reg          rsp_use_new_keys,// encrypt answer with new key/iv
   input  wire         rsp_ready,
   // comparator control
   output reg          cmp_off_pulse,
   // pwm generator control
   output reg          pwm_cfg_pulse,
   output reg  [IO_W-1:0] pwm_io,
   output reg  [7:0]   pwm_duty,
   output reg  [1:0]   pwm_fmt,
   output reg  [31:0]  pwm_value,
   input  wire [31:0]  pwm_achieved,    // real value in requested format
   // aes configuration, shared with tag encrypt/decrypt
   output reg  [127:0] aes_iv,
   output reg  [127:0] aes_key,
   output reg          aes_update_pulse
);
   // ==========================================================
   // states
   localparam S_IDLE = 5'b00001;   // waiting for code
   localparam S_ARGS = 5'b00010;   // collecting arguments
   localparam S_EXEC = 5'b00100;   // act on command
   localparam S_HEAD = 5'b01000;   // answer status beat
   localparam S_DATA = 5'b10000;   // answer data beats

   reg [4:0]   state_reg;
   reg [7:0]   code_reg;           // current command
   reg [7:0]   cnt_reg;            // argument / reply byte counter
   reg [127:0] arg_reg;            // argument shift store, lsb first
   reg [7:0]   status_reg;         // status for answer
   reg [7:0]   rlen_reg;           // reply data length
   reg [127:0] rdat_reg;           // reply data, lsb first out
   reg         newkey_reg;         // answer follows crypto change

   // ==========================================================
   // operating notes
   // one command is handled at a time: code, arguments, action,
   // then a status beat and any data beats back to the framer.
   // cmd_ready is high only while idle or collecting arguments,
   // so a host that keeps streaming is simply stalled.
   //
   // the command code must arrive with cmd_start; a beat without
   // it while idle is ignored, which resynchronises after a glitch.
   //
   // arguments are shifted in from the top of a 128-bit store.
   // a full sixteen-byte value therefore lands with its first
   // byte in bits [7:0], matching the lsb-first order on the wire.
   // shorter sets are brought down by the alignment shift below.
   //
   // the argument phase ends at the expected length or at the
   // host's last-byte mark, whichever comes first; a count that
   // does not match the expected length is answered with the
   // error status and changes nothing.
   //
   // the action cycle is the only place where configuration
   // outputs change. a refused pwm request leaves pwm_io,
   // pwm_duty, pwm_fmt and pwm_value as they were, so a running
   // waveform is not disturbed by a bad request.
   //
   // the one-cycle pulses (comparator off, pwm load, aes update)
   // rise on the edge that leaves the action cycle; the status
   // beat follows one cycle later, so the far side has seen the
   // pulse before the answer is on its way.
   //
   // the achieved pwm value is read back while the status beat is
   // pending. the generator therefore has at least one cycle after
   // its load pulse before its answer is taken.
   //
   // the answer header and each data beat hold until the framer
   // accepts them, then drop for one cycle. this keeps the beat
   // boundaries plain for a framer that samples on ready alone.
   //
   // rsp_use_new_keys tells the framer that this answer belongs to
   // a key or vector change and must already go out under the new
   // values; padding to whole cipher blocks is the framer's job.
   //
   // no timer enforces the host's settling gap after a crypto
   // change; the block would take the next command at once.
   //
   // stopping a pwm output is not handled here: the host uses the
   // io-state command, which belongs to another block.
   //
   // reset clears the stored key and vector to zero; a host that
   // relies on encryption must load both after every reset.
   //
   // the iv read answer copies the vector in the action cycle, so
   // a later update cannot tear the bytes already being sent.
   //
   // unknown codes are answered with the error status and no data.
   // the code byte is still consumed, so the stream stays aligned.
   //
   // pwm_io is cut to IO_W bits only after the range check on the
   // full byte, so an index above the channel count never aliases.
   //
   // the state register falls back to idle on any illegal code.

   // expected argument length per command
   function [7:0] arg_len;
      input [7:0] c;
      begin
         case (c)
            `PCCH_CMD_PWM_EN: arg_len = `PCCH_PWM_ARG_LEN;
            `PCCH_CMD_IV_SET: arg_len = `PCCH_BLK_LEN;
            `PCCH_CMD_KEY_SET: arg_len = `PCCH_BLK_LEN;
            default: arg_len = 8'h00;
         endcase
      end
   endfunction

   // ==========================================================
   // argument alignment
   // bytes enter at the top of arg_reg, so a short set sits high;
   // shifting by the missing byte count brings byte 0 down to [7:0]
   wire [127:0] arg_al = arg_reg >> {8'h10 - cnt_reg, 3'b000};

   // pwm argument checks
   wire [7:0]  a_io   = arg_al[7:0];
   wire [7:0]  a_duty = arg_al[15:8];
   wire [7:0]  a_fmt  = arg_al[23:16];
   wire [31:0] a_val  = arg_al[8*`PCCH_PWM_VAL_OFS +: 32];
   wire io_ok   = (a_io < PWM_CHANNELS);
   wire duty_ok = (a_duty >= `PCCH_DUTY_MIN) && (a_duty <= `PCCH_DUTY_MAX);
   wire fmt_ok  = (a_fmt <= `PCCH_FMT_FLT_S);
   wire pwm_ok  = io_ok && duty_ok && fmt_ok;

   assign cmd_ready = (state_reg == S_IDLE) || (state_reg == S_ARGS);

   // ==========================================================
   // main sequencer
   always @(posedge clk) begin
      if (reset) begin
         state_reg        <= S_IDLE;
         code_reg         <= 8'h00;
         cnt_reg          <= 8'h00;
         arg_reg          <= 128'h0;
         status_reg       <= `PCCH_ST_ACK;
         rlen_reg         <= 8'h00;
         rdat_reg         <= 128'h0;
         newkey_reg       <= 1'b0;
         rsp_start        <= 1'b0;
         rsp_status       <= 8'h00;
         rsp_valid        <= 1'b0;
         rsp_byte         <= 8'h00;
         rsp_last         <= 1'b0;
         rsp_use_new_keys <= 1'b0;
         cmp_off_pulse    <= 1'b0;
         pwm_cfg_pulse    <= 1'b0;
         pwm_io           <= {IO_W{1'b0}};
         pwm_duty         <= 8'h00;
         pwm_fmt          <= 2'b00;
         pwm_value        <= 32'h0;
         aes_iv           <= `PCCH_IV_RESET;
         aes_key          <= `PCCH_KEY_RESET;
         aes_update_pulse <= 1'b0;
      end else begin
         // pulses default low
         cmp_off_pulse    <= 1'b0;
         pwm_cfg_pulse    <= 1'b0;
         aes_update_pulse <= 1'b0;
         case (state_reg)
            S_IDLE: begin
               // take command code
               if (cmd_valid && cmd_start) begin
                  code_reg <= cmd_byte;
                  cnt_reg  <= 8'h00;
                  arg_reg  <= 128'h0;
                  if (cmd_last || arg_len(cmd_byte) == 8'h00)
                     state_reg <= S_EXEC;
                  else
                     state_reg <= S_ARGS;
               end
            end
            S_ARGS: begin
               // collect bytes lsb first
               if (cmd_valid) begin
                  arg_reg <= {cmd_byte, arg_reg[127:8]};
                  cnt_reg <= cnt_reg + 8'h01;
                  if (cmd_last || cnt_reg + 8'h01 == arg_len(code_reg))
                     state_reg <= S_EXEC;
               end
            end
            S_EXEC: begin
               // check the argument count, then act on the command
               status_reg <= `PCCH_ST_ACK;
               rlen_reg   <= 8'h00;
               newkey_reg <= 1'b0;
               state_reg  <= S_HEAD;
               if (cnt_reg != arg_len(code_reg)) begin
                  status_reg <= `PCCH_ST_ERR;                       // length mismatch
               end else begin
                  case (code_reg)
                     `PCCH_CMD_CMP_OFF: begin
                        cmp_off_pulse <= 1'b1;
                     end
                     `PCCH_CMD_PWM_EN: begin
                        if (pwm_ok) begin
                           pwm_io        <= a_io[IO_W-1:0];
                           pwm_duty      <= a_duty;
                           pwm_fmt       <= a_fmt[1:0];
                           pwm_value     <= a_val;
                           pwm_cfg_pulse <= 1'b1;
                           rlen_reg      <= `PCCH_PWM_REPLY_LEN;
                        end else begin
                           status_reg <= `PCCH_ST_ERR;
                        end
                     end
                     `PCCH_CMD_IV_SET: begin
                        aes_iv           <= arg_reg;
                        aes_update_pulse <= 1'b1;
                        newkey_reg       <= 1'b1;
                     end
                     `PCCH_CMD_KEY_SET: begin
                        aes_key          <= arg_reg;
                        aes_update_pulse <= 1'b1;
                        newkey_reg       <= 1'b1;
                     end
                     `PCCH_CMD_IV_READ: begin
                        rdat_reg <= aes_iv;
                        rlen_reg <= `PCCH_BLK_LEN;
                     end
                     default: begin
                        status_reg <= `PCCH_ST_ERR;                 // unknown code
                     end
                  endcase
               end
            end
            S_HEAD: begin
               // present status; pwm reply captured one cycle after config
               if (code_reg == `PCCH_CMD_PWM_EN)
                  rdat_reg <= {96'h0, pwm_achieved};
               if (!rsp_start) begin
                  rsp_start        <= 1'b1;
                  rsp_status       <= status_reg;
                  rsp_last         <= (rlen_reg == 8'h00);
                  rsp_use_new_keys <= newkey_reg;
               end else if (rsp_ready) begin
                  rsp_start <= 1'b0;
                  rsp_last  <= 1'b0;
                  cnt_reg   <= 8'h00;
                  state_reg <= (rlen_reg == 8'h00) ? S_IDLE : S_DATA;
               end
            end
            S_DATA: begin
               // stream reply bytes lsb first
               if (!rsp_valid) begin
                  rsp_valid <= 1'b1;
                  rsp_byte  <= rdat_reg[7:0];
                  rsp_last  <= (cnt_reg + 8'h01 == rlen_reg);
               end else if (rsp_ready) begin
                  rsp_valid <= 1'b0;
                  rsp_last  <= 1'b0;
                  rdat_reg  <= {8'h00, rdat_reg[127:8]};
                  cnt_reg   <= cnt_reg + 8'h01;
                  if (cnt_reg + 8'h01 == rlen_reg)
                     state_reg <= S_IDLE;
               end
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end
endmodule

// ### pcch_consts.vh
`ifndef PCCH_CONSTS_VH
`define PCCH_CONSTS_VH
// ==========================================================
// command codes
`define PCCH_CMD_CMP_OFF    8'h0F
`define PCCH_CMD_PWM_EN     8'h10
`define PCCH_CMD_IV_SET     8'h11
`define PCCH_CMD_KEY_SET    8'h12
`define PCCH_CMD_IV_READ    8'h13
// ==========================================================
// pwm argument layout and limits
`define PCCH_PWM_ARG_LEN    8'h07
`define PCCH_PWM_VAL_OFS    8'h03
`define PCCH_DUTY_MIN       8'h01
`define PCCH_DUTY_MAX       8'h63
`define PCCH_FMT_U32_HZ     8'h00
`define PCCH_FMT_FLT_HZ     8'h01
`define PCCH_FMT_U32_US     8'h02
`define PCCH_FMT_FLT_S      8'h03
`define PCCH_PWM_REPLY_LEN  8'h04
// ==========================================================
// crypto block size
`define PCCH_BLK_LEN        8'h10
// ==========================================================
// answer status codes
`define PCCH_ST_ACK         8'h00
`define PCCH_ST_ERR         8'h01
// ==========================================================
// reset values
`define PCCH_IV_RESET       128'h0
`define PCCH_KEY_RESET      128'h0
// ==========================================================
// settling time after crypto change (host side), ms
`define PCCH_SETTLE_MS      8'h32
`endif

// ### pcch_far_model.sv
`timescale 1ns/1ns
// ==========================================
// framer and pwm generator stand-in
module pcch_far_model (
   input  wire        clk,
   input  wire [31:0] pwm_value,
   output reg         rsp_ready,
   output wire [31:0] pwm_achieved
);
   integer seed = 32'h5A5A; // own stall pattern
   // achieved value differs from the request
   assign pwm_achieved = pwm_value ^ 32'h00FF00FF;
   initial rsp_ready = 1'b0;
   // random stalls, ready low about one cycle in four
   always @(negedge clk) begin
      rsp_ready <= ($random(seed) & 3) != 0;
   end
endmodule

// ### pcch_props.sv
`timescale 1ns/1ns
`include "pcch_consts.vh"
// ==========================================
// checker on handler ports
module pcch_props #(
   parameter PWM_CHANNELS = 4,
   parameter IO_W         = 8
) (
   input wire            clk,
   input wire            reset,
   input wire            cmd_ready,
   input wire            rsp_start,
   input wire [7:0]      rsp_status,
   input wire            rsp_valid,
   input wire [7:0]      rsp_byte,
   input wire            rsp_last,
   input wire            rsp_use_new_keys,
   input wire            rsp_ready,
   input wire            cmp_off_pulse,
   input wire            pwm_cfg_pulse,
   input wire [IO_W-1:0] pwm_io,
   input wire [7:0]      pwm_duty,
   input wire            aes_update_pulse
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // ack header with no data after it
   sequence s_ack_bare;
      rsp_start && rsp_status == `PCCH_ST_ACK && rsp_last;
   endsequence
   // ack header with data beats to follow
   sequence s_ack_data;
      rsp_start && rsp_status == `PCCH_ST_ACK && !rsp_last;
   endsequence
   AST_CMP: assert property (cmp_off_pulse |=> s_ack_bare)
      else $error("comparator off not answered by bare ack");
   AST_PWM: assert property (pwm_cfg_pulse |=> s_ack_data)
      else $error("pwm config not answered by ack with data");
   AST_KEYS: assert property (aes_update_pulse |=> s_ack_bare ##0 rsp_use_new_keys)
      else $error("crypto change not answered by bare ack under new keys");
   AST_RANGE: assert property (pwm_cfg_pulse |-> pwm_duty >= 8'h01 && pwm_duty <= 8'h63
      && pwm_io < PWM_CHANNELS)
      else $error("pwm loaded with out of range arguments");
   AST_HOLD: assert property (rsp_start && !rsp_ready |=> rsp_start && $stable(rsp_status))
      else $error("answer header dropped before accepted");
   AST_DHOLD: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_byte))
      else $error("answer byte changed before accepted");
   AST_BUSY: assert property (rsp_start || rsp_valid |-> !cmd_ready)
      else $error("command taken while answering");
   AST_END: assert property (rsp_valid && rsp_ready && rsp_last |=> !rsp_valid && !rsp_start)
      else $error("answer continued past last beat");
endmodule

// ### tb_top.sv
`timescale 1ns/1ns
`include "pcch_consts.vh"
// ==========================================
// testbench top
module tb_top;
   reg          clk = 1'b0, reset = 1'b1, cmd_start = 1'b0, cmd_valid = 1'b0, cmd_last = 1'b0;
   reg  [7:0]   cmd_byte = 8'h00, st, a [0:15], q [$];
   wire         cmd_ready, rsp_start, rsp_valid, rsp_last, rsp_use_new_keys, rsp_ready;
   wire         cmp_off_pulse, pwm_cfg_pulse, aes_update_pulse;
   wire [7:0]   rsp_status, rsp_byte, pwm_io, pwm_duty;
   wire [1:0]   pwm_fmt;
   wire [31:0]  pwm_value, pwm_achieved;
   wire [127:0] aes_iv, aes_key;
   integer      num_errors = 0, compares = 0, seed = 32'h94b0, n_cmp = 0, i, n, k;
   reg          done;
   reg  [127:0] v, vi, r;
   reg  [7:0]   d;
   always #50 clk = ~clk;
   pcch_cmd_handler i_pcch_cmd_handler (.clk(clk), .reset(reset), .cmd_start(cmd_start),
      .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_last(cmd_last), .cmd_ready(cmd_ready),
      .rsp_start(rsp_start), .rsp_status(rsp_status), .rsp_valid(rsp_valid),
      .rsp_byte(rsp_byte), .rsp_last(rsp_last), .rsp_use_new_keys(rsp_use_new_keys),
      .rsp_ready(rsp_ready), .cmp_off_pulse(cmp_off_pulse), .pwm_cfg_pulse(pwm_cfg_pulse),
      .pwm_io(pwm_io), .pwm_duty(pwm_duty), .pwm_fmt(pwm_fmt), .pwm_value(pwm_value),
      .pwm_achieved(pwm_achieved), .aes_iv(aes_iv), .aes_key(aes_key),
      .aes_update_pulse(aes_update_pulse));
   pcch_far_model i_pcch_far_model (.clk(clk), .pwm_value(pwm_value), .rsp_ready(rsp_ready),
      .pwm_achieved(pwm_achieved));
   // answer monitor at accepted beats
   always @(posedge clk) begin
      if (cmp_off_pulse === 1'b1) n_cmp = n_cmp + 1;
      if (rsp_start === 1'b1 && rsp_ready) st = rsp_status;
      if (rsp_valid === 1'b1 && rsp_ready) q.push_back(rsp_byte);
      if ((rsp_start || rsp_valid) && rsp_ready && rsp_last === 1'b1) done = 1'b1;
   end
   // compare and count
   task chk(input [127:0] seen, input [127:0] exp, input string nm);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("Error %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // one command beat, held until ready
   task beat(input [7:0] b, input s, input l);
      begin
         @(negedge clk);
         cmd_valid = 1'b1;
         cmd_start = s;
         cmd_byte = b;
         cmd_last = l;
         for (k = 0; k < 50 && cmd_ready !== 1'b1; k = k + 1) @(negedge clk);
      end
   endtask
   // whole command, then wait for its answer
   task cmd(input [7:0] c, input integer len);
      begin
         q = {};
         done = 1'b0;
         beat(c, 1'b1, len == 0);
         for (i = 0; i < len; i = i + 1) beat(a[i], 1'b0, i == len - 1);
         @(negedge clk);
         cmd_valid = 1'b0;
         cmd_last = 1'b0;
         for (k = 0; k < 300 && !done; k = k + 1) @(negedge clk);
         chk(done, 1'b1, "answer end");
      end
   endtask
   task end_sim;
      begin
         $display("errors %0d compares %0d", num_errors, compares);
         if (num_errors == 0 && compares > 0) $display("All checks passed");
         else $display("Checks failed");
         $finish;
      end
   endtask
   // watchdog
   initial begin
      #3000000;
      num_errors = num_errors + 1;
      end_sim;
   end
   // main sequence
   initial begin
      repeat (20) @(posedge clk);
      @(negedge clk) reset = 1'b0;
      cmd(`PCCH_CMD_CMP_OFF, 0);
      chk({st, q.size(), n_cmp, rsp_use_new_keys}, {8'h00, 32'd0, 32'd1, 1'b0}, "cmp off");
      // iv then key from random bytes
      for (n = 0; n < 2; n = n + 1) begin
         for (i = 0; i < 16; i = i + 1) a[i] = $random(seed);
         for (i = 0; i < 16; i = i + 1) v[8*i +: 8] = a[i];
         cmd(n ? `PCCH_CMD_KEY_SET : `PCCH_CMD_IV_SET, 16);
         chk(n ? aes_key : aes_iv, v, "aes value");
         chk({st, q.size(), rsp_use_new_keys}, {8'h00, 32'd0, 1'b1}, "aes ack");
         if (n == 0) vi = v;
         repeat (100) @(negedge clk); // shortened settle gap
      end
      cmd(`PCCH_CMD_IV_READ, 0);
      for (i = 0; i < 16; i = i + 1) r[8*i +: 8] = q[i];
      chk({st, q.size(), r, rsp_use_new_keys}, {8'h00, 32'd16, vi, 1'b0}, "iv read");
      // pwm: four good formats, then four refused cases; refused ones leave settings as they were
      for (n = 0; n < 8; n = n + 1) begin
         v = {$random(seed), $random(seed)};
         d = (n == 0) ? 8'h01 : (n == 1) ? 8'h63 : 8'h01 + v[47:40] % 8'h63;
         r = {pwm_value, pwm_io, pwm_fmt, pwm_duty};
         a[0] = (n == 6) ? 8'h04 : v[33:32];
         a[1] = (n == 4) ? 8'h00 : (n == 5) ? 8'h64 : d;
         a[2] = (n == 7) ? 8'h04 : n % 4;
         for (i = 0; i < 4; i = i + 1) a[3+i] = v[8*i +: 8];
         cmd(`PCCH_CMD_PWM_EN, 7);
         for (i = 0; i < 4 && n < 4; i = i + 1) v[64+8*i +: 8] = q[i];
         if (n < 4) chk({st, q.size(), pwm_io, pwm_duty, pwm_fmt, pwm_value, v[95:64]},
            {8'h00, 32'd4, a[0], a[1], a[2][1:0], v[31:0], v[31:0] ^ 32'h00FF00FF}, "pwm ok");
         else chk({st, q.size(), pwm_value, pwm_io, pwm_fmt, pwm_duty},
            {8'h01, 32'd0, r[49:0]}, "pwm bad");
      end
      end_sim;
   end
endmodule
bind pcch_cmd_handler pcch_props #(.PWM_CHANNELS(PWM_CHANNELS), .IO_W(IO_W)) i_pcch_props (
   .clk(clk), .reset(reset), .cmd_ready(cmd_ready), .rsp_start(rsp_start),
   .rsp_status(rsp_status), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .rsp_last(rsp_last),
   .rsp_use_new_keys(rsp_use_new_keys), .rsp_ready(rsp_ready), .cmp_off_pulse(cmp_off_pulse),
   .pwm_cfg_pulse(pwm_cfg_pulse), .pwm_io(pwm_io), .pwm_duty(pwm_duty),
   .aes_update_pulse(aes_update_pulse));
